// File: hw/dlc_pkg.sv
// constants, field layout and decode helpers for the demod loop config block
// assumes one 20 MHz system clock and byte-wide register access by index
package dlc_pkg;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_FILT_CFG = 8'h1f;
    localparam logic [7:0] ADDR_LOOP_CFG = 8'h20;
    localparam logic [7:0] ADDR_INPUT_CFG = 8'h23;
    localparam logic [7:0] ADDR_AGC_CFG = 8'h24;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_FILT_CFG = 8'h00;
    localparam logic [7:0] RST_LOOP_CFG = 8'h00;
    localparam logic [7:0] RST_INPUT_CFG = 8'h00;
    localparam logic [7:0] RST_AGC_CFG = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FILT_INV_BIT = 6;
    localparam int FILT_BYP_BIT = 7;
    localparam int LOOP_GAIN_LSB = 0;
    localparam int AFC_MODE_LSB = 2;
    localparam int THR_LSB = 4;
    localparam int REACQ_BIT = 7;
    localparam int INSEL_LSB = 0;
    localparam int ADC_GAIN_LSB = 2;
    localparam int AGC_N_LSB = 0;
    localparam int DC_EN_BIT = 5;
    localparam logic [7:0] LOOP_CFG_RD_MASK = 8'h7f;
    localparam logic [7:0] INPUT_CFG_RD_MASK = 8'h7f;
    localparam logic [7:0] AGC_CFG_RD_MASK = 8'h3f;

    // ------------------------------------------------------------
    // codes and limits
    // ------------------------------------------------------------
    localparam int SAMPLE_W = 10;
    localparam logic [1:0] INSEL_UNSIGNED = 2'h0;
    localparam logic [1:0] INSEL_SIGNED = 2'h1;
    localparam logic [1:0] INSEL_ANALOG = 2'h2;
    localparam logic [1:0] AFC_AUTO = 2'h0;
    localparam logic [1:0] AFC_FORCE_OFF = 2'h1;
    localparam logic [1:0] AFC_FORCE_ON = 2'h2;
    localparam logic [4:0] AGC_N_MAX = 5'h14;
    localparam logic [4:0] ADC_GAIN_MAX = 5'h14;
    localparam int DC_AVG_LOG2 = 10;
    localparam int AGC_CNT_W = 21;

    typedef enum logic {LS_ACQUIRE, LS_TRACK} dlc_loop_state_t;

    // lock threshold code to whole degrees
    function automatic logic [7:0] dlc_lock_thr(input logic [2:0] code);
        case (code)
            3'h0: dlc_lock_thr = 8'h01;
            3'h1: dlc_lock_thr = 8'h02;
            3'h2: dlc_lock_thr = 8'h05;
            3'h3: dlc_lock_thr = 8'h0a;
            3'h4: dlc_lock_thr = 8'h0f;
            3'h5: dlc_lock_thr = 8'h14;
            default: dlc_lock_thr = 8'h19;
        endcase
    endfunction : dlc_lock_thr

    // clamp a 5-bit setting to its valid maximum
    function automatic logic [4:0] dlc_clamp5(input logic [4:0] v, input logic [4:0] vmax);
        dlc_clamp5 = (v > vmax) ? vmax : v;
    endfunction : dlc_clamp5

endpackage : dlc_pkg

// File: hw/dlc_dc_remove.sv
// dc bias estimator and subtractor for one sample channel
// assumes a symbol tick from the timing loop and signed samples
`timescale 1ns/1ps
module dlc_dc_remove
    import dlc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // control
    input wire logic enable_in,
    input wire logic symbol_tick_in,
    // samples
    input wire logic valid_in,
    input wire logic signed [SAMPLE_W-1:0] x_in,
    output logic signed [SAMPLE_W-1:0] y_out,
    output logic valid_out
);
    localparam int ACC_W = SAMPLE_W + DC_AVG_LOG2;
    localparam logic [DC_AVG_LOG2-1:0] CNT_LAST = '1;
    localparam logic signed [SAMPLE_W:0] SAT_HI = 11'sh1ff;
    localparam logic signed [SAMPLE_W:0] SAT_LO = -11'sh200;

    logic signed [ACC_W-1:0] acc_ff, nxt_acc;
    logic [DC_AVG_LOG2-1:0] cnt_ff, nxt_cnt;
    logic signed [SAMPLE_W-1:0] est_ff, nxt_est;
    logic signed [SAMPLE_W-1:0] y_ff, nxt_y;
    logic vld_ff, nxt_vld;
    logic signed [SAMPLE_W:0] diff;

    // ------------------------------------------------------------
    // estimate over 1024 symbols, one sample per tick, block average
    // ------------------------------------------------------------
    always_comb begin
        nxt_acc = acc_ff;
        nxt_cnt = cnt_ff;
        nxt_est = est_ff;
        if (!enable_in) begin
            nxt_acc = '0;
            nxt_cnt = '0;
            nxt_est = '0;
        end else if (symbol_tick_in) begin
            if (cnt_ff == CNT_LAST) begin
                nxt_est = SAMPLE_W'((acc_ff + ACC_W'(x_in)) >>> DC_AVG_LOG2);
                nxt_acc = '0;
            end else begin
                nxt_acc = acc_ff + ACC_W'(x_in);
            end
            nxt_cnt = cnt_ff + 1'b1;
        end
        diff = (SAMPLE_W + 1)'(x_in) - (SAMPLE_W + 1)'(est_ff);
        nxt_vld = valid_in;
        nxt_y = y_ff;
        if (valid_in) begin
            if (!enable_in) begin
                nxt_y = x_in;
            end else if (diff > SAT_HI) begin
                nxt_y = SAMPLE_W'(SAT_HI);
            end else if (diff < SAT_LO) begin
                nxt_y = SAMPLE_W'(SAT_LO);
            end else begin
                nxt_y = SAMPLE_W'(diff);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            acc_ff <= '0;
            cnt_ff <= '0;
            est_ff <= '0;
            y_ff <= '0;
            vld_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            cnt_ff <= nxt_cnt;
            est_ff <= nxt_est;
            y_ff <= nxt_y;
            vld_ff <= nxt_vld;
        end
    end

    assign y_out = y_ff;
    assign valid_out = vld_ff;

endmodule : dlc_dc_remove

// File: hw/dlc_agc_pace.sv
// pacer: one pulse every 2^n symbols for the front-end gain update
// assumes n already clamped to the valid range
`timescale 1ns/1ps
module dlc_agc_pace
    import dlc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // control
    input wire logic symbol_tick_in,
    input wire logic [4:0] n_in,
    // pulse
    output logic update_out
);
    logic [AGC_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic upd_ff, nxt_upd;
    logic [AGC_CNT_W-1:0] last;

    always_comb begin
        last = AGC_CNT_W'((AGC_CNT_W + 1)'(1) << n_in) - 1'b1;
        nxt_cnt = cnt_ff;
        nxt_upd = 1'b0;
        if (symbol_tick_in) begin
            if (cnt_ff >= last) begin
                // shrinking n mid-count restarts cleanly
                nxt_cnt = '0;
                nxt_upd = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cnt_ff <= '0;
            upd_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            upd_ff <= nxt_upd;
        end
    end

    assign update_out = upd_ff;

endmodule : dlc_agc_pace

// File: hw/dlc_top.sv
// demodulator-2 carrier loop config and shared receive front-end config
// assumes synchronous register writes by index and a symbol tick input
`timescale 1ns/1ps

module dlc_top
    import dlc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // digital sample connector
    input wire logic [SAMPLE_W-1:0] dig_i_in,
    input wire logic [SAMPLE_W-1:0] dig_q_in,
    input wire logic dig_valid_in,
    // built-in converter on the analog input connector
    input wire logic signed [SAMPLE_W-1:0] adc_i_in,
    input wire logic signed [SAMPLE_W-1:0] adc_q_in,
    input wire logic adc_valid_in,
    // datapath status
    input wire logic symbol_tick_in,
    input wire logic [7:0] phase_err_std_in,
    input wire logic [7:0] front_end_gain_loop_in,
    // conditioned samples
    output logic signed [SAMPLE_W-1:0] samp_i_out,
    output logic signed [SAMPLE_W-1:0] samp_q_out,
    output logic samp_valid_out,
    // loop controls
    output logic filter_bypass_out,
    output logic [3:0] loop_gain_mult_out,
    output logic afc_on_out,
    output logic carrier_lock_out,
    output logic reacq_out,
    output logic loop_acquire_out,
    // front end controls
    output logic [4:0] adc_gain_db_out,
    output logic [7:0] front_end_gain_ctrl_out
);
    localparam logic signed [SAMPLE_W-1:0] S_MIN = -10'sh200;
    localparam logic signed [SAMPLE_W-1:0] S_MAX = 10'sh1ff;
    localparam logic [SAMPLE_W-1:0] MSB_FLIP = 10'h200;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [7:0] filt_cfg_ff, nxt_filt_cfg;
    logic [7:0] loop_cfg_ff, nxt_loop_cfg;
    logic [7:0] in_cfg_ff, nxt_in_cfg;
    logic [7:0] agc_cfg_ff, nxt_agc_cfg;
    logic [7:0] rdata_ff, nxt_rdata;
    logic reacq_ff, nxt_reacq;

    always_comb begin
        nxt_filt_cfg = filt_cfg_ff;
        nxt_loop_cfg = loop_cfg_ff;
        nxt_in_cfg = in_cfg_ff;
        nxt_agc_cfg = agc_cfg_ff;
        nxt_reacq = 1'b0;
        if (reg_wr_in) begin
            case (reg_addr_in)
                ADDR_FILT_CFG: nxt_filt_cfg = reg_wdata_in;
                ADDR_LOOP_CFG: begin
                    nxt_loop_cfg = reg_wdata_in & LOOP_CFG_RD_MASK;
                    // one pulse per write of one
                    nxt_reacq = reg_wdata_in[REACQ_BIT];
                end
                ADDR_INPUT_CFG: nxt_in_cfg = reg_wdata_in & INPUT_CFG_RD_MASK;
                ADDR_AGC_CFG: nxt_agc_cfg = reg_wdata_in & AGC_CFG_RD_MASK;
                default: nxt_filt_cfg = filt_cfg_ff;
            endcase
        end
        case (reg_addr_in)
            ADDR_FILT_CFG: nxt_rdata = filt_cfg_ff;
            ADDR_LOOP_CFG: nxt_rdata = loop_cfg_ff;
            ADDR_INPUT_CFG: nxt_rdata = in_cfg_ff;
            ADDR_AGC_CFG: nxt_rdata = agc_cfg_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            filt_cfg_ff <= RST_FILT_CFG;
            loop_cfg_ff <= RST_LOOP_CFG;
            in_cfg_ff <= RST_INPUT_CFG;
            agc_cfg_ff <= RST_AGC_CFG;
            rdata_ff <= 8'h00;
            reacq_ff <= 1'b0;
        end else begin
            filt_cfg_ff <= nxt_filt_cfg;
            loop_cfg_ff <= nxt_loop_cfg;
            in_cfg_ff <= nxt_in_cfg;
            agc_cfg_ff <= nxt_agc_cfg;
            rdata_ff <= nxt_rdata;
            reacq_ff <= nxt_reacq;
        end
    end

    // field views
    logic [1:0] gain_code;
    logic [1:0] afc_mode;
    logic [2:0] thr_code;
    logic [1:0] in_sel;
    logic q_invert;
    logic dc_en;
    assign gain_code = loop_cfg_ff[LOOP_GAIN_LSB +: 2];
    assign afc_mode = loop_cfg_ff[AFC_MODE_LSB +: 2];
    assign thr_code = loop_cfg_ff[THR_LSB +: 3];
    assign in_sel = in_cfg_ff[INSEL_LSB +: 2];
    assign q_invert = filt_cfg_ff[FILT_INV_BIT];
    assign dc_en = agc_cfg_ff[DC_EN_BIT];

    // ------------------------------------------------------------
    // carrier loop control
    // ------------------------------------------------------------
    dlc_loop_state_t state_ff, nxt_state;
    logic lock_ff, nxt_lock;
    logic afc_ff, nxt_afc;
    logic [3:0] gmul_ff, nxt_gmul;

    always_comb begin
        nxt_lock = phase_err_std_in < dlc_lock_thr(thr_code);
        nxt_state = state_ff;
        case (state_ff)
            LS_ACQUIRE: begin
                if (!reacq_ff && lock_ff) begin
                    nxt_state = LS_TRACK;
                end
            end
            LS_TRACK: begin
                if (reacq_ff || !lock_ff) begin
                    nxt_state = LS_ACQUIRE;
                end
            end
            default: nxt_state = LS_ACQUIRE;
        endcase
        case (afc_mode)
            AFC_AUTO: nxt_afc = (nxt_state == LS_ACQUIRE);
            AFC_FORCE_OFF: nxt_afc = 1'b0;
            AFC_FORCE_ON: nxt_afc = 1'b1;
            // test code: kept quiet rather than guess its use
            default: nxt_afc = 1'b0;
        endcase
        nxt_gmul = 4'h1 << gain_code;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            state_ff <= LS_ACQUIRE;
            lock_ff <= 1'b0;
            afc_ff <= 1'b0;
            gmul_ff <= 4'h1;
        end else begin
            state_ff <= nxt_state;
            lock_ff <= nxt_lock;
            afc_ff <= nxt_afc;
            gmul_ff <= nxt_gmul;
        end
    end

    // ------------------------------------------------------------
    // input select and spectrum inversion
    // ------------------------------------------------------------
    logic signed [SAMPLE_W-1:0] si_ff, nxt_si;
    logic signed [SAMPLE_W-1:0] sq_ff, nxt_sq;
    logic sv_ff, nxt_sv;
    logic signed [SAMPLE_W-1:0] raw_q;

    always_comb begin
        nxt_si = si_ff;
        nxt_sq = sq_ff;
        nxt_sv = 1'b0;
        raw_q = '0;
        case (in_sel)
            INSEL_UNSIGNED: begin
                nxt_sv = dig_valid_in;
                nxt_si = dig_i_in ^ MSB_FLIP;
                raw_q = dig_q_in ^ MSB_FLIP;
            end
            INSEL_SIGNED: begin
                nxt_sv = dig_valid_in;
                nxt_si = dig_i_in;
                raw_q = dig_q_in;
            end
            INSEL_ANALOG: begin
                nxt_sv = adc_valid_in;
                nxt_si = adc_i_in;
                raw_q = adc_q_in;
            end
            default: nxt_sv = 1'b0;
        endcase
        if (q_invert) begin
            nxt_sq = (raw_q == S_MIN) ? S_MAX : -raw_q;
        end else begin
            nxt_sq = raw_q;
        end
        if (!nxt_sv) begin
            nxt_si = si_ff;
            nxt_sq = sq_ff;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            si_ff <= '0;
            sq_ff <= '0;
            sv_ff <= 1'b0;
        end else begin
            si_ff <= nxt_si;
            sq_ff <= nxt_sq;
            sv_ff <= nxt_sv;
        end
    end

    // ------------------------------------------------------------
    // dc bias removal, one per channel
    // ------------------------------------------------------------
    logic signed [SAMPLE_W-1:0] ch_x [2];
    logic signed [SAMPLE_W-1:0] ch_y [2];
    logic [1:0] ch_v;
    assign ch_x[0] = si_ff;
    assign ch_x[1] = sq_ff;

    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_dc
            dlc_dc_remove u_dc (
                .clk_in(sys_clk_in),
                .resetn_in(resetn_in),
                .enable_in(dc_en),
                .symbol_tick_in(symbol_tick_in),
                .valid_in(sv_ff),
                .x_in(ch_x[gc]),
                .y_out(ch_y[gc]),
                .valid_out(ch_v[gc])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // front end gain
    // ------------------------------------------------------------
    logic agc_upd;
    logic [7:0] fe_ff, nxt_fe;
    logic [4:0] adcg_ff, nxt_adcg;

    dlc_agc_pace u_pace (
        .clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .symbol_tick_in(symbol_tick_in),
        .n_in(dlc_clamp5(agc_cfg_ff[AGC_N_LSB +: 5], AGC_N_MAX)),
        .update_out(agc_upd)
    );

    always_comb begin
        nxt_fe = agc_upd ? front_end_gain_loop_in : fe_ff;
        nxt_adcg = dlc_clamp5(in_cfg_ff[ADC_GAIN_LSB +: 5], ADC_GAIN_MAX);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            fe_ff <= 8'h00;
            adcg_ff <= 5'h00;
        end else begin
            fe_ff <= nxt_fe;
            adcg_ff <= nxt_adcg;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_out = rdata_ff;
    assign samp_i_out = ch_y[0];
    assign samp_q_out = ch_y[1];
    assign samp_valid_out = &ch_v;
    assign filter_bypass_out = filt_cfg_ff[FILT_BYP_BIT];
    assign loop_gain_mult_out = gmul_ff;
    assign afc_on_out = afc_ff;
    assign carrier_lock_out = lock_ff;
    assign reacq_out = reacq_ff;
    assign loop_acquire_out = (state_ff == LS_ACQUIRE);
    assign adc_gain_db_out = adcg_ff;
    assign front_end_gain_ctrl_out = fe_ff;

endmodule : dlc_top

// File: dv/dlc_properties.sv
// port checker for dlc_top, bound after the module
// assumes one clock domain and synchronous active-low reset
`timescale 1ns/1ps
module dlc_properties
    import dlc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // inputs watched
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic dig_valid_in,
    input wire logic adc_valid_in,
    input wire logic symbol_tick_in,
    input wire logic [7:0] phase_err_std_in,
    // outputs watched
    input wire logic samp_valid_out,
    input wire logic filter_bypass_out,
    input wire logic [3:0] loop_gain_mult_out,
    input wire logic afc_on_out,
    input wire logic carrier_lock_out,
    input wire logic reacq_out,
    input wire logic [4:0] adc_gain_db_out,
    input wire logic [7:0] front_end_gain_ctrl_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    logic loop_wr;
    assign loop_wr = reg_wr_in && reg_addr_in == ADDR_LOOP_CFG;
    // quiet cycle after the write, so no later write overrides the mode
    sequence s_mode(logic [1:0] m);
        loop_wr && reg_wdata_in[3:2] == m ##1 !loop_wr;
    endsequence
    byp_follow_a: assert property (
        reg_wr_in && reg_addr_in == ADDR_FILT_CFG |=> filter_bypass_out == $past(reg_wdata_in[7]))
        else $error("bypass flag wrong");
    gain_scale_a: assert property (
        loop_wr |=> ##1 loop_gain_mult_out == 4'h1 << $past(reg_wdata_in[1:0], 2))
        else $error("loop gain wrong");
    reacq_pulse_a: assert property (loop_wr && reg_wdata_in[7] |=> reacq_out)
        else $error("reacquire pulse missing");
    reacq_cause_a: assert property (reacq_out |-> $past(loop_wr && reg_wdata_in[7]))
        else $error("reacquire without write");
    afc_on_a: assert property (s_mode(AFC_FORCE_ON) |=> afc_on_out)
        else $error("forced-on mode not on");
    afc_off_a: assert property (s_mode(AFC_FORCE_OFF) |=> !afc_on_out)
        else $error("forced-off mode not off");
    lock_low_a: assert property (phase_err_std_in == 8'h00 |=> carrier_lock_out)
        else $error("lock missing");
    lock_high_a: assert property (phase_err_std_in > 8'h18 |=> !carrier_lock_out)
        else $error("false lock");
    samp_lat_a: assert property (
        samp_valid_out |-> $past(dig_valid_in || adc_valid_in, 2))
        else $error("sample without input");
    adc_gain_a: assert property (
        reg_wr_in && reg_addr_in == ADDR_INPUT_CFG && reg_wdata_in[6:2] <= ADC_GAIN_MAX
        |=> ##1 adc_gain_db_out == $past(reg_wdata_in[6:2], 2))
        else $error("converter gain wrong");
    fe_pace_a: assert property (
        $changed(front_end_gain_ctrl_out) |-> $past(symbol_tick_in, 2))
        else $error("gain output off pace");
endmodule : dlc_properties

bind dlc_top dlc_properties u_props (.sys_clk_in, .resetn_in, .reg_addr_in, .reg_wr_in,
    .reg_wdata_in, .dig_valid_in, .adc_valid_in, .symbol_tick_in, .phase_err_std_in,
    .samp_valid_out, .filter_bypass_out, .loop_gain_mult_out, .afc_on_out, .carrier_lock_out,
    .reacq_out, .adc_gain_db_out, .front_end_gain_ctrl_out);

// File: dv/dlc_far_end.sv
// timing loop model: symbol ticks and a gain-loop value
// assumes the block samples on the rising edge
`timescale 1ns/1ps
module dlc_far_end #(
    parameter int TICK_GAP = 4
) (
    // clock
    input wire logic sys_clk_in,
    // timing loop side
    output logic symbol_tick_out,
    output logic [7:0] gain_loop_out
);
    int cnt = 0;
    initial symbol_tick_out = 1'b0;
    initial gain_loop_out = 8'h00;
    // new gain value each tick, so every update shows
    always @(negedge sys_clk_in) begin
        cnt <= (cnt + 1) % TICK_GAP;
        symbol_tick_out <= (cnt == 0);
        if (cnt == 0) begin
            gain_loop_out <= gain_loop_out + 8'h01;
        end
    end
endmodule : dlc_far_end

// File: dv/tb_top.sv
// self-checking bench for the loop and input config block
// assumes dlc_pkg and the far-end model dlc_far_end
`timescale 1ns/1ps
module tb_top
    import dlc_pkg::*;
;
    logic clk, rstn, wr, dv, av, sv, byp, afc, lock, reacq, acq, tick;
    logic [7:0] addr, wdata, rdata, pstd, gl, fe;
    logic [9:0] di, dq, ai, aq, si, sq;
    logic [3:0] mult;
    logic [4:0] adcg;
    int num_errors = 0;
    int check_count = 0;
    dlc_top u_dut (.sys_clk_in(clk), .resetn_in(rstn), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .dig_i_in(di), .dig_q_in(dq),
        .dig_valid_in(dv), .adc_i_in(ai), .adc_q_in(aq), .adc_valid_in(av),
        .symbol_tick_in(tick), .phase_err_std_in(pstd), .front_end_gain_loop_in(gl),
        .samp_i_out(si), .samp_q_out(sq), .samp_valid_out(sv), .filter_bypass_out(byp),
        .loop_gain_mult_out(mult), .afc_on_out(afc), .carrier_lock_out(lock),
        .reacq_out(reacq), .loop_acquire_out(acq), .adc_gain_db_out(adcg),
        .front_end_gain_ctrl_out(fe));
    dlc_far_end #(.TICK_GAP(4)) u_far (.sys_clk_in(clk), .symbol_tick_out(tick),
        .gain_loop_out(gl));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    // all drives at the falling edge, one idle edge before each write
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wreg
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        @(negedge clk);
        d = rdata;
    endtask : rd
    task automatic t_regs();
        logic [7:0] ad [4] = '{ADDR_FILT_CFG, ADDR_LOOP_CFG, ADDR_INPUT_CFG, ADDR_AGC_CFG};
        logic [7:0] mk [4] = '{8'hff, LOOP_CFG_RD_MASK, INPUT_CFG_RD_MASK, AGC_CFG_RD_MASK};
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            rd(ad[i], d);
            check(d, 8'h00);
            wreg(ad[i], 8'hff);
            rd(ad[i], d);
            check(d, mk[i]);
            wreg(ad[i], 8'h00);
        end
        wreg(8'h21, 8'hff);
        rd(8'h21, d);
        check(d, 8'h00);
    endtask : t_regs
    task automatic t_gain();
        pstd = 8'hff;
        // every gain code is exercised while running
        for (int c = 0; c < 4; c++) begin
            wreg(ADDR_LOOP_CFG, 8'(c));
            // gain multiplier is a second register stage behind the field
            @(negedge clk);
            check(mult, 10'h1 << c);
            check(reacq, 1'b0);
        end
    endtask : t_gain
    task automatic t_lock();
        logic [7:0] thr [8] = '{8'h01, 8'h02, 8'h05, 8'h0a, 8'h0f, 8'h14, 8'h19, 8'h19};
        for (int c = 0; c < 8; c++) begin
            wreg(ADDR_LOOP_CFG, {1'b0, 3'(c), 4'h4});
            pstd = thr[c] - 8'h01;
            @(negedge clk);
            check(lock, 1'b1);
            pstd = thr[c];
            @(negedge clk);
            check(lock, 1'b0);
        end
    endtask : t_lock
    task automatic t_afc();
        pstd = 8'hff;
        wreg(ADDR_LOOP_CFG, 8'h08);
        @(negedge clk);
        check(afc, 1'b1);
        wreg(ADDR_LOOP_CFG, 8'h04);
        @(negedge clk);
        check(afc, 1'b0);
        wreg(ADDR_LOOP_CFG, 8'h0c);
        @(negedge clk);
        check(afc, 1'b0);
        wreg(ADDR_LOOP_CFG, 8'h60);
        @(negedge clk);
        check(afc, 1'b1);
        pstd = 8'h00;
        repeat (3) @(negedge clk);
        check(acq, 1'b0);
        check(afc, 1'b0);
        wreg(ADDR_LOOP_CFG, 8'he0);
        check(reacq, 1'b1);
        @(negedge clk);
        check(reacq, 1'b0);
        check(acq, 1'b1);
        // frequency control forced off once tracking
        wreg(ADDR_LOOP_CFG, 8'h64);
    endtask : t_afc
    task automatic smp(input logic an, input logic [9:0] i, q, ei, eq);
        int n;
        {di, dq, ai, aq} = {i, q, i, q};
        dv = !an;
        av = an;
        @(negedge clk);
        dv = 1'b0;
        av = 1'b0;
        for (n = 1; sv !== 1'b1 && n < 5; n++) @(negedge clk);
        check(10'(n), 10'h2);
        check(si, ei);
        check(sq, eq);
    endtask : smp
    task automatic t_inputs();
        smp(1'b0, 10'h000, 10'h3ff, 10'h200, 10'h1ff);
        wreg(ADDR_INPUT_CFG, 8'h01);
        smp(1'b0, 10'h005, 10'h3fb, 10'h005, 10'h3fb);
        wreg(ADDR_FILT_CFG, 8'hc0);
        check(byp, 1'b1);
        smp(1'b0, 10'h200, 10'h200, 10'h200, 10'h1ff);
        wreg(ADDR_FILT_CFG, 8'h00);
        check(byp, 1'b0);
        wreg(ADDR_INPUT_CFG, 8'h2a);
        @(negedge clk);
        check(adcg, 10'h0a);
        smp(1'b1, 10'h123, 10'h2aa, 10'h123, 10'h2aa);
        wreg(ADDR_INPUT_CFG, 8'h7f);
        @(negedge clk);
        check(adcg, ADC_GAIN_MAX);
        dv = 1'b1;
        av = 1'b1;
        repeat (4) @(negedge clk);
        check(sv, 1'b0);
        dv = 1'b0;
        av = 1'b0;
    endtask : t_inputs
    // ticks seen between two changes of the gain output
    task automatic gap(output int t);
        logic [7:0] v;
        v = fe;
        t = 0;
        for (int k = 0; k < 200 && fe === v; k++) begin
            @(negedge clk);
            if (tick === 1'b1) t++;
        end
    endtask : gap
    task automatic t_agc();
        int t;
        for (int n = 0; n < 4; n++) begin
            wreg(ADDR_AGC_CFG, 8'(n));
            gap(t);
            gap(t);
            check(10'(t), 10'h1 << n);
        end
    endtask : t_agc
    task automatic t_dc();
        wreg(ADDR_INPUT_CFG, 8'h01);
        {di, dq} = {10'h008, 10'h3f8};
        dv = 1'b1;
        wreg(ADDR_AGC_CFG, 8'h20);
        repeat (4200) @(negedge clk);
        check(si, 10'h000);
        check(sq, 10'h000);
        // removal switched off again by software
        wreg(ADDR_AGC_CFG, 8'h00);
        repeat (4) @(negedge clk);
        check(si, 10'h008);
        dv = 1'b0;
    endtask : t_dc
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        conclude();
    end
    initial begin
        {rstn, wr, dv, av, addr, wdata, pstd} = '0;
        {di, dq, ai, aq} = '0;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        t_regs();
        $display("register test done");
        t_gain();
        $display("gain test done");
        t_lock();
        $display("lock test done");
        t_afc();
        $display("frequency control test done");
        t_inputs();
        $display("input test done");
        t_agc();
        $display("gain pacing test done");
        t_dc();
        $display("bias removal test done");
        conclude();
    end
endmodule : tb_top
